// ==== core/qdr_pkg.sv ====
// qdr_pkg: shared constants and state types of the quad double-rate read link
package qdr_pkg;
   localparam logic [7:0] OPC_READ        = 8'hed;
   localparam logic [7:0] OPC_READ_WIDE   = 8'hee;
   localparam logic [3:0] MODE_CONT       = 4'ha;
   localparam logic [3:0] DUMMY_DEFAULT   = 4'h6;
   localparam int         WIDE_SEL_BIT    = 7;
   localparam logic [5:0] OPC_SDR_CLOCKS  = 6'h08;
   localparam logic [5:0] OPC_QUAD_CLOCKS = 6'h02;
   localparam logic [5:0] ADDR_NIBS_3     = 6'h06;
   localparam logic [5:0] ADDR_NIBS_4     = 6'h08;
   localparam int         SCLK_HALF       = 8;
   localparam logic [3:0] IO_IDLE         = 4'hf;
   localparam logic [5:0] DEV_SYNC_RST    = 6'h10;

   typedef enum logic [2:0] {
      DEV_IDLE   = 3'h0,
      DEV_OPC    = 3'h1,
      DEV_ADDR   = 3'h2,
      DEV_DUMMY  = 3'h3,
      DEV_DATA   = 3'h4,
      DEV_IGNORE = 3'h5
   } qdr_dev_state_t;

   typedef enum logic [2:0] {
      H_IDLE  = 3'h0,
      H_OPC   = 3'h1,
      H_ADDR  = 3'h2,
      H_DUMMY = 3'h3,
      H_DATA  = 3'h4,
      H_END   = 3'h5
   } qdr_host_state_t;
endpackage

// ==== core/qdr_link.sv ====
// qdr_link: serial clock, select and four shared data lines between both ends
`timescale 1ns/100ps
`default_nettype none
interface qdr_link;
   logic       sclk;
   logic       cs_n;
   logic [3:0] host_io_out;
   logic       host_io_oe;
   logic [3:0] dev_io_out;
   logic       dev_io_oe;
   logic [3:0] io;

   // pull-ups hold undriven lines high
   assign io = dev_io_oe ? dev_io_out : (host_io_oe ? host_io_out : qdr_pkg::IO_IDLE);

   modport host (output sclk, cs_n, host_io_out, host_io_oe, input io);
   modport dev (input sclk, cs_n, io, output dev_io_out, dev_io_oe);
endinterface
`default_nettype wire

// ==== core/qdr_sync.sv ====
// qdr_sync: two-flop synchroniser for pins entering the clock domain
`timescale 1ns/100ps
`default_nettype none
module qdr_sync #(
   parameter int           W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         i_clk,
   input  wire logic         i_reset_n,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] meta;

   // first stage feeds only the second
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         meta <= RST;
         o_q  <= RST;
      end else begin
         meta <= i_d;
         o_q  <= meta;
      end
   end
endmodule
`default_nettype wire

// ==== core/qdr_host_end.sv ====
// qdr_host_end: host controller end issuing quad double-rate reads
`timescale 1ns/100ps
`default_nettype none
module qdr_host_end #(
   parameter int HALF_CYCLES = qdr_pkg::SCLK_HALF
) (
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   qdr_link.host            lnk,
   input  wire logic        i_start,
   input  wire logic        i_wide_opcode,
   input  wire logic        i_wide_address_select,
   input  wire logic        i_four_lane_command_mode,
   input  wire logic        i_quad_lanes_enable,
   input  wire logic        i_skip_opcode,
   input  wire logic [31:0] i_addr,
   input  wire logic [7:0]  i_mode_byte,
   input  wire logic [3:0]  i_dummy_clocks,
   input  wire logic [7:0]  i_length,
   output logic             o_busy,
   output logic [7:0]       o_data,
   output logic             o_data_valid,
   output logic             o_done
);
   qdr_pkg::qdr_host_state_t st;
   logic [7:0]  hcnt;
   logic        tick, mid, rising, quad, wide, skip, sclk, cs_n;
   logic [31:0] sh, addr_q;
   logic [7:0]  mode_q, len_q, nbytes;
   logic [3:0]  dummy_q, io_s, nib, launch, io_out;
   logic        launch_oe, io_oe;
   logic [5:0]  k, opc_last, addr_last, dummy_last;

   qdr_sync #(.W(4), .RST(qdr_pkg::IO_IDLE)) u_sync (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_d       (lnk.io),
      .o_q       (io_s)
   );

   assign lnk.sclk        = sclk;
   assign lnk.cs_n        = cs_n;
   assign lnk.host_io_out = io_out;
   assign lnk.host_io_oe  = io_oe;

   assign tick       = (hcnt == 8'(HALF_CYCLES - 1));
   assign mid        = (hcnt == 8'(HALF_CYCLES / 2 - 1));
   assign rising     = ~sclk;
   assign opc_last   = (quad ? qdr_pkg::OPC_QUAD_CLOCKS : qdr_pkg::OPC_SDR_CLOCKS) - 6'h01;
   assign addr_last  = (wide ? qdr_pkg::ADDR_NIBS_4 : qdr_pkg::ADDR_NIBS_3) - 6'h01;
   assign dummy_last = {1'b0, dummy_q, 1'b0} - 6'h01;

   // divider for the serial clock; runs only during a transfer
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         hcnt <= 8'h00;
      end else if (st == qdr_pkg::H_IDLE || tick) begin
         hcnt <= 8'h00;
      end else begin
         hcnt <= hcnt + 8'h01;
      end
   end

   // value put on the lines for the coming edge
   always_comb begin
      launch    = sh[31:28];
      launch_oe = 1'b1;
      unique case (st)
         qdr_pkg::H_OPC: begin
            if (!quad) begin
               launch = {3'b111, sh[31]};
            end
         end
         qdr_pkg::H_ADDR: begin
         end
         qdr_pkg::H_DUMMY: begin
            launch_oe = (k == 6'h00);  // low mode nibble left floating
         end
         qdr_pkg::H_IDLE, qdr_pkg::H_DATA, qdr_pkg::H_END: begin
            launch_oe = 1'b0;
         end
         default: begin
            launch_oe = 1'b0;
         end
      endcase
   end

   // lines change mid-half so the far end samples a settled value
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         io_out <= qdr_pkg::IO_IDLE;
         io_oe  <= 1'b0;
      end else if (mid) begin
         io_out <= launch;
         io_oe  <= launch_oe;
      end
   end

   // transfer sequencing, one step per serial clock edge; the opcode phase steps on rising edges only
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st <= qdr_pkg::H_IDLE;
         k <= 6'h00;
         sh <= 32'h0000_0000;
         skip <= 1'b0;
         sclk <= 1'b0;
         cs_n <= 1'b1;
         quad <= 1'b0;
         wide <= 1'b0;
         addr_q <= 32'h0000_0000;
         mode_q <= 8'h00;
         len_q <= 8'h00;
         dummy_q <= qdr_pkg::DUMMY_DEFAULT;
         nbytes <= 8'h00;
         nib <= 4'h0;
         o_data <= 8'h00;
         o_data_valid <= 1'b0;
         o_done <= 1'b0;
         o_busy <= 1'b0;
      end else begin
         o_data_valid <= 1'b0;
         o_done <= 1'b0;
         if (tick && st != qdr_pkg::H_END) begin
            sclk <= ~sclk;
         end
         unique case (st)
            qdr_pkg::H_IDLE: begin
               // single-lane opcode needs lanes enabled first
               if (i_start && (i_four_lane_command_mode || i_quad_lanes_enable)) begin
                  cs_n <= 1'b0;
                  o_busy <= 1'b1;
                  quad <= i_four_lane_command_mode;
                  wide <= i_wide_opcode | i_wide_address_select;
                  addr_q <= i_addr;
                  mode_q <= i_mode_byte;
                  len_q <= i_length;
                  dummy_q <= (i_dummy_clocks == 4'h0) ? qdr_pkg::DUMMY_DEFAULT : i_dummy_clocks;
                  k <= 6'h00;
                  nbytes <= 8'h00;
                  skip <= 1'b0;
                  if (i_skip_opcode) begin
                     st <= qdr_pkg::H_ADDR;
                     sh <= (i_wide_opcode | i_wide_address_select) ? i_addr : {i_addr[23:0], 8'h00};
                  end else begin
                     st <= qdr_pkg::H_OPC;
                     sh <= {i_wide_opcode ? qdr_pkg::OPC_READ_WIDE : qdr_pkg::OPC_READ, 24'h00_0000};
                  end
               end
            end
            qdr_pkg::H_OPC: begin
               if (tick && rising) begin
                  sh <= quad ? {sh[27:0], 4'h0} : {sh[30:0], 1'b0};
                  k <= k + 6'h01;
                  if (k == opc_last) begin
                     st <= qdr_pkg::H_ADDR;
                     k <= 6'h00;
                     skip <= 1'b1;  // falling edge after the opcode carries nothing
                     sh <= wide ? addr_q : {addr_q[23:0], 8'h00};
                  end
               end
            end
            qdr_pkg::H_ADDR: begin
               if (tick) begin
                  if (skip) begin
                     skip <= 1'b0;
                  end else begin
                     sh <= {sh[27:0], 4'h0};
                     k <= k + 6'h01;
                     if (k == addr_last) begin
                        st <= qdr_pkg::H_DUMMY;
                        k <= 6'h00;
                        sh <= {mode_q, 24'h00_0000};
                     end
                  end
               end
            end
            qdr_pkg::H_DUMMY: begin
               if (tick) begin
                  k <= k + 6'h01;
                  if (k == dummy_last) begin
                     st <= qdr_pkg::H_DATA;
                  end
               end
            end
            qdr_pkg::H_DATA: begin
               if (tick) begin
                  nib <= io_s;
                  if (!rising) begin
                     o_data <= {nib, io_s};
                     o_data_valid <= 1'b1;
                     nbytes <= nbytes + 8'h01;
                     if (nbytes == len_q - 8'h01) begin
                        st <= qdr_pkg::H_END;
                     end
                  end
               end
            end
            qdr_pkg::H_END: begin
               if (mid) begin
                  cs_n <= 1'b1;
               end
               if (tick) begin
                  st <= qdr_pkg::H_IDLE;
                  o_busy <= 1'b0;
                  o_done <= 1'b1;
               end
            end
            default: begin
               st <= qdr_pkg::H_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== core/qdr_flash_end.sv ====
// qdr_flash_end: flash-side interpreter of the quad double-rate read
// Function
// - host sets lane enable before single-lane read
// - address and data: four bits per edge
// - any start address accepted
// - address increments per byte, wraps to zero
// - EDh, narrow select: three address bytes
// - EDh, wide select: four address bytes
// - EEh always takes four address bytes
// - opcode, address, dummy, data in order
// - dummy clock count configurable, default six
// - host picks dummy count, device obeys; the device takes its count from its own i_dummy_clocks
// - select high ends read, output released
// - mode nibble A enters continuous read
// - other mode nibble leaves continuous read
// - read rejected while write cycle active
// - four-lane mode: opcode in two clocks
// - four-lane mode ignores lane enable
// - host floats lines after mode nibble
// - wide select is bank register bit seven
`timescale 1ns/100ps
`default_nettype none
module qdr_flash_end #(
   parameter int ADDR_BITS = 25
) (
   input  wire logic                 i_clk,
   input  wire logic                 i_reset_n,
   qdr_link.dev                      lnk,
   input  wire logic                 i_quad_lanes_enable,
   input  wire logic                 i_four_lane_command_mode,
   input  wire logic                 i_write_cycle_active,
   input  wire logic [7:0]           i_bank_addr,
   input  wire logic [3:0]           i_dummy_clocks,
   input  wire logic [7:0]           i_mem_data,
   output logic      [ADDR_BITS-1:0] o_mem_addr,
   output logic                      o_continuous_read_mode,
   output logic                      o_read_active,
   output logic                      o_rejected
);
   qdr_pkg::qdr_dev_state_t state;
   logic [5:0]  sync_q;
   logic        sclk_s, sclk_d, cs_n_s;
   logic [3:0]  io_s;
   logic        rise, fall, any_edge;
   logic [5:0]  cnt, opc_last, addr_last, dummy_last;
   logic [3:0]  dummy_clks;
   logic [7:0]  opc, next_opc;
   logic [31:0] addr, full_addr;
   logic        wide, next_wide, skip, opc_ok, addr_done, dummy_done;
   logic [3:0]  io_out, lo_nib;
   logic        io_oe;

   // sclk, select and lines all come from the far side
   qdr_sync #(.W(6), .RST(qdr_pkg::DEV_SYNC_RST)) u_sync (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_d       ({lnk.sclk, lnk.cs_n, lnk.io}),
      .o_q       (sync_q)
   );
   assign sclk_s = sync_q[5];
   assign cs_n_s = sync_q[4];
   assign io_s   = sync_q[3:0];

   assign lnk.dev_io_out = io_out;
   assign lnk.dev_io_oe  = io_oe;

   // edge finder on the synchronised serial clock
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sclk_d <= 1'b0;
      end else begin
         sclk_d <= sclk_s;
      end
   end
   assign rise     = sclk_s & ~sclk_d;
   assign fall     = ~sclk_s & sclk_d;
   assign any_edge = rise | fall;

   // opcode shifts one bit or one nibble per rising edge
   assign next_opc = i_four_lane_command_mode ? {opc[3:0], io_s} : {opc[6:0], io_s[0]};
   assign opc_last = (i_four_lane_command_mode ? qdr_pkg::OPC_QUAD_CLOCKS
                                               : qdr_pkg::OPC_SDR_CLOCKS) - 6'h01;

   // lane enable only matters for single-lane opcodes
   assign opc_ok = !i_write_cycle_active
                 && (i_four_lane_command_mode || i_quad_lanes_enable)
                 && (next_opc == qdr_pkg::OPC_READ || next_opc == qdr_pkg::OPC_READ_WIDE);

   // address width chosen by opcode or by the bank register top bit
   assign next_wide = (next_opc == qdr_pkg::OPC_READ_WIDE)
                    || i_bank_addr[qdr_pkg::WIDE_SEL_BIT];
   assign addr_last = (wide ? qdr_pkg::ADDR_NIBS_4 : qdr_pkg::ADDR_NIBS_3) - 6'h01;

   // zero would leave no turnaround, so it falls back to the default
   assign dummy_clks = (i_dummy_clocks == 4'h0) ? qdr_pkg::DUMMY_DEFAULT : i_dummy_clocks;
   assign dummy_last = {1'b0, dummy_clks, 1'b0} - 6'h01;

   assign addr_done  = (state == qdr_pkg::DEV_ADDR) && any_edge && !skip && (cnt == addr_last);
   assign dummy_done = (state == qdr_pkg::DEV_DUMMY) && any_edge && (cnt == dummy_last);

   // narrow addresses take their top bits from the bank register
   assign full_addr = wide ? {addr[27:0], io_s}
                           : {1'b0, i_bank_addr[qdr_pkg::WIDE_SEL_BIT-1:0], addr[19:0], io_s};

   // command sequencer; select high always returns to idle
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state <= qdr_pkg::DEV_IDLE;
         cnt   <= 6'h00;
         skip  <= 1'b0;
         wide  <= 1'b0;
      end else if (cs_n_s) begin
         state <= qdr_pkg::DEV_IDLE;
         cnt   <= 6'h00;
         skip  <= 1'b0;
      end else begin
         unique case (state)
            qdr_pkg::DEV_IDLE: begin
               cnt <= 6'h00;
               if (i_write_cycle_active) begin
                  state <= qdr_pkg::DEV_IGNORE;
               end else if (o_continuous_read_mode) begin
                  state <= qdr_pkg::DEV_ADDR;  // no opcode phase
                  skip  <= 1'b0;
               end else begin
                  state <= qdr_pkg::DEV_OPC;
               end
            end
            qdr_pkg::DEV_OPC: begin
               if (rise) begin
                  cnt <= cnt + 6'h01;
                  if (cnt == opc_last) begin
                     cnt <= 6'h00;
                     if (opc_ok) begin
                        state <= qdr_pkg::DEV_ADDR;
                        wide  <= next_wide;
                        skip  <= 1'b1;  // the fall closing the opcode clock is unused
                     end else begin
                        state <= qdr_pkg::DEV_IGNORE;
                     end
                  end
               end
            end
            qdr_pkg::DEV_ADDR: begin
               if (any_edge) begin
                  if (skip) begin
                     skip <= 1'b0;
                  end else if (addr_done) begin
                     state <= qdr_pkg::DEV_DUMMY;
                     cnt   <= 6'h00;
                  end else begin
                     cnt <= cnt + 6'h01;
                  end
               end
            end
            qdr_pkg::DEV_DUMMY: begin
               if (dummy_done) begin
                  state <= qdr_pkg::DEV_DATA;
               end else if (any_edge) begin
                  cnt <= cnt + 6'h01;
               end
            end
            qdr_pkg::DEV_DATA: begin
               state <= qdr_pkg::DEV_DATA;  // runs until select rises
            end
            qdr_pkg::DEV_IGNORE: begin
               state <= qdr_pkg::DEV_IGNORE;  // rest of the frame is dropped
            end
            default: begin
               state <= qdr_pkg::DEV_IGNORE;
            end
         endcase
      end
   end

   // opcode and address shift registers
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         opc  <= 8'h00;
         addr <= 32'h0000_0000;
      end else if (state == qdr_pkg::DEV_OPC && rise) begin
         opc <= next_opc;
      end else if (state == qdr_pkg::DEV_ADDR && any_edge && !skip) begin
         addr <= {addr[27:0], io_s};
      end
   end

   // continuous read flag follows the high mode nibble of each read
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_continuous_read_mode <= 1'b0;
      end else if (state == qdr_pkg::DEV_DUMMY && rise && cnt == 6'h00 && !cs_n_s) begin
         o_continuous_read_mode <= (io_s == qdr_pkg::MODE_CONT);
      end
   end

   // read data: high nibble launched on a fall, low nibble on a rise
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         io_out     <= qdr_pkg::IO_IDLE;
         io_oe      <= 1'b0;
         lo_nib     <= 4'h0;
         o_mem_addr <= '0;
      end else begin
         if (cs_n_s) begin
            io_oe <= 1'b0;
         end else if (dummy_done || (state == qdr_pkg::DEV_DATA && fall)) begin
            io_oe  <= 1'b1;  // lines turn round only after the last dummy clock
            io_out <= i_mem_data[7:4];
            lo_nib <= i_mem_data[3:0];
         end else if (state == qdr_pkg::DEV_DATA && rise) begin
            io_out     <= lo_nib;
            o_mem_addr <= o_mem_addr + ADDR_BITS'(1);  // wraps past the top
         end
         if (addr_done && !cs_n_s) begin
            o_mem_addr <= full_addr[ADDR_BITS-1:0];
         end
      end
   end

   // status seen by the surrounding chip
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_read_active <= 1'b0;
         o_rejected    <= 1'b0;
      end else begin
         o_read_active <= (state == qdr_pkg::DEV_DATA) && !cs_n_s;
         o_rejected    <= !cs_n_s
                        && ((state == qdr_pkg::DEV_IDLE && i_write_cycle_active)
                            || (state == qdr_pkg::DEV_OPC && rise && cnt == opc_last && !opc_ok));
      end
   end
endmodule
`default_nettype wire

// ==== testbench/qdr_link_props.sv ====
// qdr_link_props: wire-level checks on the link between the host end and the flash end
`timescale 1ns/100ps
`default_nettype none
module qdr_link_props (
   input  wire logic       i_clk,
   input  wire logic       i_reset_n,
   input  wire logic       sclk,
   input  wire logic       cs_n,
   input  wire logic       host_io_oe,
   input  wire logic       dev_io_oe,
   input  wire logic [3:0] io
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   // a device still driving after select high would collide with the next frame
   a_dev_release_end: assert property ($rose(cs_n) |-> ##[1:4] !dev_io_oe)
      else $error("device still drives the lines after select high");
   // only one end may drive the shared lines
   a_no_io_contention: assert property (!(host_io_oe && dev_io_oe))
      else $error("both ends drive the lines");
   // select moves only while the serial clock is low
   a_select_clock_low: assert property ($changed(cs_n) |-> !sclk && !$past(sclk))
      else $error("select changed with serial clock high");
   // serial clock stands still outside frames
   a_idle_clock_still: assert property (cs_n |-> !sclk)
      else $error("serial clock high while deselected");
   // each half period lasts eight system clocks
   a_half_period_hold: assert property ($changed(sclk) |=> $stable(sclk)[*7])
      else $error("serial clock half period too short");
   // lines are settled at every edge where a nibble is taken
   a_edge_io_settled: assert property ($changed(sclk) |-> $stable(io))
      else $error("lines changed at a serial clock edge");
   // frames are separated by a deselected gap
   a_select_gap_min: assert property ($rose(cs_n) |=> cs_n[*3])
      else $error("select high gap too short");
   // first clock edge comes a full half period after select falls
   a_first_edge_lead: assert property ($fell(cs_n) |-> !sclk[*8])
      else $error("first serial clock edge too early");
   // host starts driving the first phase soon after select falls
   a_host_opens_frame: assert property ($fell(cs_n) |-> ##[3:5] (host_io_oe && !dev_io_oe))
      else $error("host did not drive the first phase");

   c_frame_start: cover property ($fell(cs_n));
   c_device_drives: cover property ($rose(dev_io_oe));
   c_end_in_data: cover property ($rose(cs_n) && dev_io_oe);
endmodule
`default_nettype wire

// ==== testbench/tb_quad_ddr_read_command.sv ====
// tb_quad_ddr_read_command: both link ends checked against a byte-level read model
`timescale 1ns/100ps
`default_nettype none
module tb_quad_ddr_read_command;
   logic        i_clk = 1'b0;
   logic        i_reset_n = 1'b0;
   logic        start = 1'b0, wop = 1'b0, wsel = 1'b0, fl = 1'b0;
   logic        ql = 1'b0, skip = 1'b0, wact = 1'b0, dql = 1'b0;
   logic [31:0] addr = 32'h0000_0000;
   logic [7:0]  mode = 8'h00;
   logic [7:0]  len = 8'h01;
   logic [3:0]  dum = 4'h0;
   logic [6:0]  bank7 = 7'h00;
   wire  logic        busy, dvalid, done, cont, ract, rej;
   wire  logic [7:0]  data;
   wire  logic [7:0]  mem_data;
   wire  logic [24:0] mem_addr;
   logic [7:0]  exp_q[$];
   logic        cont_m = 1'b0;
   int          err_total = 0;
   int          checked = 0;
   int          rej_n = 0;
   int          ract_n = 0;

   always #20 i_clk = ~i_clk;

   qdr_link lnk ();
   qdr_host_end u_qdr_host_end (.i_clk(i_clk), .i_reset_n(i_reset_n), .lnk(lnk), .i_start(start),
      .i_wide_opcode(wop), .i_wide_address_select(wsel), .i_four_lane_command_mode(fl),
      .i_quad_lanes_enable(ql), .i_skip_opcode(skip), .i_addr(addr), .i_mode_byte(mode),
      .i_dummy_clocks(dum), .i_length(len), .o_busy(busy), .o_data(data), .o_data_valid(dvalid),
      .o_done(done));
   qdr_flash_end u_qdr_flash_end (.i_clk(i_clk), .i_reset_n(i_reset_n), .lnk(lnk), .i_quad_lanes_enable(dql),
      .i_four_lane_command_mode(fl), .i_write_cycle_active(wact), .i_bank_addr({wsel, bank7}),
      .i_dummy_clocks(dum), .i_mem_data(mem_data), .o_mem_addr(mem_addr), .o_continuous_read_mode(cont),
      .o_read_active(ract), .o_rejected(rej));
   qdr_link_props u_qdr_link_props (.i_clk(i_clk), .i_reset_n(i_reset_n), .sclk(lnk.sclk), .cs_n(lnk.cs_n),
      .host_io_oe(lnk.host_io_oe), .dev_io_oe(lnk.dev_io_oe), .io(lnk.io));

   // array contents mix low and high address bits so a wrong bank or wrap shows up
   assign mem_data = mem_addr[7:0] ^ mem_addr[24:17];

   function automatic logic [7:0] model_byte(input logic [24:0] a);
      return a[7:0] ^ a[24:17];
   endfunction

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] expv);
      checked++;
      if (seen !== expv) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, expv, seen);
      end
   endtask

   task automatic complete_run;
      if (err_total == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // every delivered byte is compared with the model queue
   always @(posedge i_clk) begin
      if (dvalid === 1'b1) begin
         if (exp_q.size() == 0) check("extra byte", 32'h1, 32'h0);
         else check("read byte", data, exp_q.pop_front());
      end
      if (rej === 1'b1) rej_n++;
      if (ract === 1'b1) ract_n++;
   end

   // one read frame: lane mode, opcode, width, skip, refused, refused by device lane enable,
   // address, mode, dummy, length
   task automatic run(input logic q, f, o, w, s, k, c, input logic [31:0] a, input logic [7:0] m,
                      input logic [3:0] d, input logic [7:0] n);
      logic [24:0] ea;
      logic [6:0]  b;
      int          r0;
      int          a0;
      b  = 7'($urandom);
      ea = (o | w) ? a[24:0] : {b[0], a[23:0]};
      for (int i = 0; i < ((n == 8'h00) ? 256 : int'(n)); i++) begin
         exp_q.push_back(k ? 8'hff : model_byte(ea));
         ea = ea + 25'h1;
      end
      if (!k) cont_m = (m[7:4] == 4'ha);
      r0 = rej_n;
      a0 = ract_n;
      @(posedge i_clk);
      ql <= q;
      dql <= q & ~c;
      fl <= f;
      wop <= o;
      wsel <= w;
      skip <= s;
      wact <= k & ~c;
      addr <= a;
      mode <= m;
      dum <= d;
      len <= n;
      bank7 <= b;
      start <= 1'b1;
      @(posedge i_clk);
      start <= 1'b0;
      @(posedge i_clk);
      check("busy", busy, 1'b1);
      for (int t = 0; t < 9000 && done !== 1'b1; t++) @(posedge i_clk);
      // a frame that never finishes counts as a mismatch here
      check("done and idle", {done, busy}, 2'b10);
      check("bytes left", exp_q.size(), 32'h0);
      check("continuous flag", cont, cont_m);
      check("rejected", rej_n - r0, k);
      check("read active", ract_n != a0, !k);
      exp_q.delete();
      repeat (4) @(posedge i_clk);
   endtask

   initial begin
      void'($urandom(94));
      repeat (16) @(posedge i_clk);
      i_reset_n <= 1'b1;
      repeat (2) @(posedge i_clk);
      run(1, 0, 0, 0, 0, 0, 0, $urandom, 8'h00, 4'h0, 8'h04);
      run(1, 0, 0, 1, 0, 0, 0, 32'h01ff_fffe, 8'h00, 4'h8, 8'h05);
      run(0, 1, 1, 0, 0, 0, 0, $urandom, 8'ha5, 4'h5, 8'h03);
      run(0, 1, 1, 0, 1, 0, 0, $urandom, 8'h00, 4'h0, 8'h02);
      run(1, 0, 1, 0, 0, 1, 0, $urandom, 8'ha0, 4'h6, 8'h02);
      run(1, 0, 0, 0, 0, 1, 1, $urandom, 8'ha0, 4'h0, 8'h02);
      run(1, 0, 0, 0, 0, 0, 0, $urandom, 8'ha3, 4'h0, 8'h01);
      run(1, 0, 0, 0, 1, 0, 0, $urandom, 8'hff, 4'h0, 8'h00);
      // single-lane start with lanes disabled must leave the host idle
      ql <= 1'b0;
      fl <= 1'b0;
      start <= 1'b1;
      @(posedge i_clk);
      start <= 1'b0;
      repeat (40) @(posedge i_clk);
      check("refused start", {busy, lnk.cs_n}, 2'b01);
      complete_run;
   end

   // a hang is cut short well past the longest expected run
   initial begin
      repeat (40000) @(posedge i_clk);
      err_total++;
      complete_run;
   end
endmodule
`default_nettype wire
